// file: rtl/sbsi_pkg.sv
// shared constants for the synchronous burst sram port
package sbsi_pkg;
   // address and data geometry
   localparam int ADDR_W    = 19;
   localparam int UPPER_W   = 17;
   localparam int LOW_W     = 2;
   localparam int LANE_W    = 9;
   localparam int LANES     = 2;
   localparam int DATA_W    = LANE_W * LANES;
   localparam int MEM_DEPTH = 524288;
   // write buffer geometry and entry field positions
   localparam int BUF_DEPTH    = 2;
   localparam int ENT_DATA_LSB = 0;
   localparam int ENT_BW_LSB   = DATA_W;
   localparam int ENT_ADDR_LSB = DATA_W + LANES;
   localparam int ENTRY_W      = ADDR_W + LANES + DATA_W;
   // control encodings and reset values
   localparam logic [1:0]        BW_NONE_N        = 2'h3;
   localparam logic              MODE_INTERLEAVED = 1'h1;
   localparam logic [1:0]        STEP_FIRST       = 2'h0;
   localparam logic [1:0]        STEP_ONE         = 2'h1;
   localparam logic [DATA_W-1:0] RD_DATA_RST      = 18'h00000;
   localparam logic [UPPER_W-1:0] ADDR_HI_RST     = 17'h00000;
   localparam logic [ADDR_W-1:0] ADDR_RST         = 19'h00000;
   // data phase that follows a sampled command
   typedef enum logic [1:0] {
      SBSI_PH_IDLE  = 2'h0,
      SBSI_PH_READ  = 2'h1,
      SBSI_PH_WRITE = 2'h2
   } sbsi_phase_type;
endpackage

// file: rtl/sbsi_burst_seq.sv
`timescale 1ns/1ps
`default_nettype none
// low two address bits for a given step of a four-word burst
module sbsi_burst_seq (
   input  wire logic [1:0] start_low,
   input  wire logic [1:0] step,
   input  wire logic       interleave,
   output logic      [1:0] addr_low
);
   // interleaved order flips bits, linear order counts and wraps
   always_comb begin
      if (interleave) begin
         addr_low = start_low ^ step;
      end else begin
         addr_low = 2'(start_low + step);
      end
   end
endmodule
`default_nettype wire

// file: rtl/sbsi_wbuf.sv
`timescale 1ns/1ps
`default_nettype none
// small fifo with valid/ready both sides and a view of every held entry
module sbsi_wbuf #(
   parameter int WIDTH = 39,
   parameter int DEPTH = 2
) (
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   input  wire logic                   in_valid,
   output logic                        in_ready,
   input  wire logic [WIDTH-1:0]       in_data,
   output logic                        out_valid,
   input  wire logic                   out_ready,
   output logic      [WIDTH-1:0]       out_data,
   output logic      [WIDTH*DEPTH-1:0] peek_data,
   output logic      [DEPTH-1:0]       peek_valid
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] store_reg [DEPTH];
   logic [PW-1:0]    rd_ptr_reg;
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW:0]      count_reg;
   logic             push;
   logic             pop;

   // honest full and empty from the occupancy count
   assign in_ready  = (count_reg != (PW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data  = store_reg[rd_ptr_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // pointers and occupancy
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rd_ptr_reg <= '0;
         wr_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : PW'(wr_ptr_reg + 1'b1);
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : PW'(rd_ptr_reg + 1'b1);
         end
         count_reg <= (PW+1)'(count_reg + {PW'(0), push} - {PW'(0), pop});
      end
   end

   // entry storage
   always_ff @(posedge clock) begin
      if (push) begin
         store_reg[wr_ptr_reg] <= in_data;
      end
   end

   // entries oldest first, for lookups by the owner
   always_comb begin
      int idx;
      idx = 0;
      for (int i = 0; i < DEPTH; i++) begin
         idx = int'(rd_ptr_reg) + i;
         if (idx >= DEPTH) begin
            idx = idx - DEPTH;
         end
         peek_data[i*WIDTH +: WIDTH] = store_reg[idx];
         peek_valid[i] = (int'(count_reg) > i);
      end
   end
endmodule
`default_nettype wire

// file: rtl/sbsi_sram_port.sv
// Overview of operation
// - address is captured only on a clock-enabled load edge with the chip selected
// - the two low captured address bits seed the burst counter
// - each nine-bit lane has its own active-low write enable
// - byte enables are ignored whenever a read is sampled
// - enabled bytes are written one cycle after the write command or step
// - clock enable high freezes everything except the standby indication as if the edge never happened
// - read/write level on load sets the operation for the whole burst
// - data transfer of a command happens one cycle after it
// - load edge with any chip enable inactive starts a deselect
// - data bus floats one cycle after a deselect starts
// - third chip enable is active high, otherwise identical to others
// - read data drives only while output enable is low
// - load edge with chip selected loads new address and control
// - advance edge steps an active burst and ignores address and read/write
// - burst-order input high gives interleaved order, low gives linear
// - everything is timed by the rising clock except output enable, snooze, mode
// - interleaved order xors the start bits with 01, 10, 11
// - linear order increments the low bits, wrapping 11 to 00
// - a write with all byte enables high leaves the array unchanged
// - snooze puts the array into standby, normal work only while low; commands still run while high, up to two writes wait in the buffer and later ones are dropped
`timescale 1ns/1ps
`default_nettype none
module sbsi_sram_port (
   input  wire logic                          clock,
   input  wire logic                          sys_rst,
   input  wire logic [sbsi_pkg::UPPER_W-1:0]  addr_upper,
   input  wire logic                          addr_bit1,
   input  wire logic                          addr_bit0,
   input  wire logic                          advance_not_load,
   input  wire logic                          read_write,
   input  wire logic                          byte_wr_en_lane_a_n,
   input  wire logic                          byte_wr_en_lane_b_n,
   input  wire logic                          chip_sel_n,
   input  wire logic                          chip_sel2_n,
   input  wire logic                          chip_sel_high,
   input  wire logic                          clk_en_n,
   input  wire logic                          out_en_n,
   input  wire logic                          burst_mode,
   input  wire logic                          snooze_request,
   input  wire logic [sbsi_pkg::LANE_W-1:0]   data_lane_a_in,
   output logic      [sbsi_pkg::LANE_W-1:0]   data_lane_a_out,
   output logic                               data_lane_a_oe_n,
   input  wire logic [sbsi_pkg::LANE_W-1:0]   data_lane_b_in,
   output logic      [sbsi_pkg::LANE_W-1:0]   data_lane_b_out,
   output logic                               data_lane_b_oe_n,
   output logic                               wr_buf_ready,
   output logic                               standby_active
);
   // array and pipeline state
   logic [sbsi_pkg::DATA_W-1:0]  mem_array [sbsi_pkg::MEM_DEPTH];
   logic [sbsi_pkg::UPPER_W-1:0] addr_hi_reg;
   logic [1:0]                   start_reg;
   logic [1:0]                   step_reg;
   logic                         burst_on_reg;
   logic                         op_read_reg;
   sbsi_pkg::sbsi_phase_type     phase_reg;
   sbsi_pkg::sbsi_phase_type     phase_next;
   logic [sbsi_pkg::ADDR_W-1:0]  phase_addr_reg;
   logic [1:0]                   phase_bw_n_reg;
   logic [sbsi_pkg::DATA_W-1:0]  rd_data_reg;
   logic                         standby_reg;
   // command decode
   logic                         selected;
   logic                         load_cmd;
   logic                         desel_cmd;
   logic                         step_cmd;
   logic                         acc_cmd;
   logic                         acc_read;
   logic [1:0]                   step_next;
   logic [1:0]                   burst_low;
   logic [sbsi_pkg::ADDR_W-1:0]  acc_addr;
   logic [1:0]                   acc_bw_n;
   logic [sbsi_pkg::DATA_W-1:0]  pin_word;
   logic [sbsi_pkg::DATA_W-1:0]  fwd_word;
   // write buffer handshake
   logic                         push_valid;
   logic                         push_ready;
   logic                         push_fire;
   logic [sbsi_pkg::ENTRY_W-1:0] push_entry;
   logic                         drain_valid;
   logic                         drain_ready;
   logic [sbsi_pkg::ENTRY_W-1:0] drain_entry;
   logic [sbsi_pkg::ENTRY_W*sbsi_pkg::BUF_DEPTH-1:0] peek_data;
   logic [sbsi_pkg::BUF_DEPTH-1:0]                    peek_valid;

   // overlay the enabled lanes of a write onto a word
   function automatic logic [sbsi_pkg::DATA_W-1:0] lane_merge(
      input logic [sbsi_pkg::DATA_W-1:0] base,
      input logic [1:0]                  bw_n,
      input logic [sbsi_pkg::DATA_W-1:0] wdata
   );
      logic [sbsi_pkg::DATA_W-1:0] res;
      res = base;
      for (int l = 0; l < sbsi_pkg::LANES; l++) begin
         if (!bw_n[l]) begin
            res[l*sbsi_pkg::LANE_W +: sbsi_pkg::LANE_W] =
               wdata[l*sbsi_pkg::LANE_W +: sbsi_pkg::LANE_W];
         end
      end
      return res;
   endfunction

   // chip select: two active low enables and one active high
   assign selected  = ~chip_sel_n & ~chip_sel2_n & chip_sel_high;
   assign load_cmd  = ~clk_en_n & ~advance_not_load & selected;
   assign desel_cmd = ~clk_en_n & ~advance_not_load & ~selected;
   assign step_cmd  = ~clk_en_n & advance_not_load & burst_on_reg;
   assign acc_cmd   = load_cmd | step_cmd;

   // next burst step and its low address bits
   assign step_next = 2'(step_reg + sbsi_pkg::STEP_ONE);

   sbsi_burst_seq u_burst_seq (
      .start_low  (start_reg),
      .step       (step_next),
      .interleave (burst_mode == sbsi_pkg::MODE_INTERLEAVED),
      .addr_low   (burst_low)
   );

   // address, operation and lane enables of the access taken this edge
   always_comb begin
      if (load_cmd) begin
         acc_addr = {addr_upper, addr_bit1, addr_bit0};
         acc_read = read_write;
      end else begin
         acc_addr = {addr_hi_reg, burst_low};
         acc_read = op_read_reg;
      end
      if (acc_read) begin
         acc_bw_n = sbsi_pkg::BW_NONE_N;
      end else begin
         acc_bw_n = {byte_wr_en_lane_b_n, byte_wr_en_lane_a_n};
      end
   end

   // data phase that the current edge sets up
   always_comb begin
      phase_next = phase_reg;
      if (!clk_en_n) begin
         if (acc_cmd) begin
            phase_next = acc_read ? sbsi_pkg::SBSI_PH_READ : sbsi_pkg::SBSI_PH_WRITE;
         end else begin
            phase_next = sbsi_pkg::SBSI_PH_IDLE;
         end
      end
   end

   // address register and burst counter
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         addr_hi_reg  <= sbsi_pkg::ADDR_HI_RST;
         start_reg    <= sbsi_pkg::STEP_FIRST;
         step_reg     <= sbsi_pkg::STEP_FIRST;
         burst_on_reg <= 1'h0;
         op_read_reg  <= 1'h1;
      end else if (!clk_en_n) begin
         if (load_cmd) begin
            addr_hi_reg  <= addr_upper;
            start_reg    <= {addr_bit1, addr_bit0};
            step_reg     <= sbsi_pkg::STEP_FIRST;
            burst_on_reg <= 1'h1;
            op_read_reg  <= read_write;
         end else if (desel_cmd) begin
            burst_on_reg <= 1'h0;
         end else if (step_cmd) begin
            step_reg <= step_next;
         end
      end
   end

   // pipeline of the pending data transfer
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         phase_reg      <= sbsi_pkg::SBSI_PH_IDLE;
         phase_addr_reg <= sbsi_pkg::ADDR_RST;
         phase_bw_n_reg <= sbsi_pkg::BW_NONE_N;
      end else if (!clk_en_n) begin
         phase_reg <= phase_next;
         if (acc_cmd) begin
            phase_addr_reg <= acc_addr;
            phase_bw_n_reg <= acc_bw_n;
         end
      end
   end

   // write data phase: lanes from the pins enter the buffer
   assign pin_word   = {data_lane_b_in, data_lane_a_in};
   assign push_valid = ~clk_en_n & (phase_reg == sbsi_pkg::SBSI_PH_WRITE)
                       & (phase_bw_n_reg != sbsi_pkg::BW_NONE_N);
   assign push_entry = {phase_addr_reg, phase_bw_n_reg, pin_word};
   assign push_fire  = push_valid & push_ready;
   // array is asleep in standby, so the buffer holds writes back
   assign drain_ready  = ~clk_en_n & ~snooze_request;
   assign wr_buf_ready = push_ready;

   sbsi_wbuf #(
      .WIDTH (sbsi_pkg::ENTRY_W),
      .DEPTH (sbsi_pkg::BUF_DEPTH)
   ) u_wbuf (
      .clock      (clock),
      .sys_rst    (sys_rst),
      .in_valid   (push_valid),
      .in_ready   (push_ready),
      .in_data    (push_entry),
      .out_valid  (drain_valid),
      .out_ready  (drain_ready),
      .out_data   (drain_entry),
      .peek_data  (peek_data),
      .peek_valid (peek_valid)
   );

   // array write from the buffer head, enabled lanes only
   always_ff @(posedge clock) begin
      if (drain_valid && drain_ready) begin
         mem_array[drain_entry[sbsi_pkg::ENT_ADDR_LSB +: sbsi_pkg::ADDR_W]] <= lane_merge(
            mem_array[drain_entry[sbsi_pkg::ENT_ADDR_LSB +: sbsi_pkg::ADDR_W]],
            drain_entry[sbsi_pkg::ENT_BW_LSB +: sbsi_pkg::LANES],
            drain_entry[sbsi_pkg::ENT_DATA_LSB +: sbsi_pkg::DATA_W]);
      end
   end

   // read word with every write still in flight laid over it, oldest first
   always_comb begin
      logic [sbsi_pkg::ENTRY_W-1:0] ent;
      ent      = '0;
      fwd_word = mem_array[acc_addr];
      for (int i = 0; i < sbsi_pkg::BUF_DEPTH; i++) begin
         ent = peek_data[i*sbsi_pkg::ENTRY_W +: sbsi_pkg::ENTRY_W];
         if (peek_valid[i] && ent[sbsi_pkg::ENT_ADDR_LSB +: sbsi_pkg::ADDR_W] == acc_addr) begin
            fwd_word = lane_merge(fwd_word, ent[sbsi_pkg::ENT_BW_LSB +: sbsi_pkg::LANES],
                                  ent[sbsi_pkg::ENT_DATA_LSB +: sbsi_pkg::DATA_W]);
         end
      end
      if (push_fire && phase_addr_reg == acc_addr) begin
         fwd_word = lane_merge(fwd_word, phase_bw_n_reg, pin_word);
      end
   end

   // read data register, loaded at the edge that takes the read
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data_reg <= sbsi_pkg::RD_DATA_RST;
      end else if (acc_cmd && acc_read) begin
         rd_data_reg <= fwd_word;
      end
   end

   // standby indication follows the snooze input
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         standby_reg <= 1'h0;
      end else begin
         standby_reg <= snooze_request;
      end
   end
   assign standby_active = standby_reg;

   // pin drivers: read phase and asynchronous output enable
   assign data_lane_a_out  = rd_data_reg[sbsi_pkg::LANE_W-1:0];
   assign data_lane_b_out  = rd_data_reg[sbsi_pkg::DATA_W-1:sbsi_pkg::LANE_W];
   assign data_lane_a_oe_n = ~((phase_reg == sbsi_pkg::SBSI_PH_READ) & ~out_en_n);
   assign data_lane_b_oe_n = ~((phase_reg == sbsi_pkg::SBSI_PH_READ) & ~out_en_n);

   // address capture on a selected load edge
   property p_load_capture;
      @(posedge clock) disable iff (sys_rst)
      load_cmd |=> (addr_hi_reg == $past(addr_upper))
                   && (start_reg == $past({addr_bit1, addr_bit0}))
                   && (step_reg == sbsi_pkg::STEP_FIRST);
   endproperty
   a_load_capture: assert property (p_load_capture)
      else $error("load edge did not capture address");

   // frozen state under clock enable high
   property p_cke_freeze;
      @(posedge clock) disable iff (sys_rst)
      clk_en_n |=> $stable(phase_reg) && $stable(rd_data_reg)
                   && $stable(step_reg) && $stable(addr_hi_reg)
                   && $stable(data_lane_a_oe_n);
   endproperty
   a_cke_freeze: assert property (p_cke_freeze)
      else $error("state moved while clock enable was high");

   // byte enables of a read are discarded
   property p_read_bw_ignored;
      @(posedge clock) disable iff (sys_rst)
      (acc_cmd && acc_read) |=> (phase_bw_n_reg == sbsi_pkg::BW_NONE_N)
                               && (phase_reg == sbsi_pkg::SBSI_PH_READ);
   endproperty
   a_read_bw_ignored: assert property (p_read_bw_ignored)
      else $error("read kept byte enables");

   // deselect floats the bus at the next cycle and ends the burst
   property p_desel_float;
      @(posedge clock) disable iff (sys_rst)
      desel_cmd |=> data_lane_a_oe_n && data_lane_b_oe_n && !burst_on_reg;
   endproperty
   a_desel_float: assert property (p_desel_float)
      else $error("bus driven after deselect");

   // output enable high always floats the pins
   property p_oe_float;
      @(posedge clock) disable iff (sys_rst)
      out_en_n |-> data_lane_a_oe_n && data_lane_b_oe_n;
   endproperty
   a_oe_float: assert property (p_oe_float)
      else $error("pins driven with output enable high");

   // a read command drives the bus in the following cycle
   property p_read_next_cycle;
      @(posedge clock) disable iff (sys_rst)
      (acc_cmd && acc_read) ##1 !out_en_n |-> !data_lane_a_oe_n && !data_lane_b_oe_n;
   endproperty
   a_read_next_cycle: assert property (p_read_next_cycle)
      else $error("read data not driven one cycle after command");

   // burst step keeps the operation and the upper address
   property p_step_op;
      @(posedge clock) disable iff (sys_rst)
      step_cmd |=> (phase_reg == ($past(op_read_reg) ? sbsi_pkg::SBSI_PH_READ
                                                      : sbsi_pkg::SBSI_PH_WRITE))
                   && (step_reg == 2'($past(step_reg) + 2'h1))
                   && $stable(addr_hi_reg);
   endproperty
   a_step_op: assert property (p_step_op)
      else $error("burst step changed operation or count");

   // interleaved burst address
   property p_interleave_addr;
      @(posedge clock) disable iff (sys_rst)
      (step_cmd && burst_mode) |=> phase_addr_reg[1:0] == (start_reg ^ step_reg);
   endproperty
   a_interleave_addr: assert property (p_interleave_addr)
      else $error("interleaved burst address wrong");

   // linear burst address
   property p_linear_addr;
      @(posedge clock) disable iff (sys_rst)
      (step_cmd && !burst_mode) |=> phase_addr_reg[1:0] == 2'(start_reg + step_reg);
   endproperty
   a_linear_addr: assert property (p_linear_addr)
      else $error("linear burst address wrong");

   // a write with some lane enabled is queued at its data edge, none otherwise
   property p_write_queued;
      @(posedge clock) disable iff (sys_rst)
      (!clk_en_n && phase_reg == sbsi_pkg::SBSI_PH_WRITE && push_ready)
         |-> push_fire == (phase_bw_n_reg != sbsi_pkg::BW_NONE_N);
   endproperty
   a_write_queued: assert property (p_write_queued)
      else $error("write data not queued as enabled");
endmodule
`default_nettype wire

// file: dv/sbsi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// master side of the shared data pins: resolves each lane from both drivers
module sbsi_host_model (
   input  wire logic        clock,
   input  wire logic        host_drive,
   input  wire logic [17:0] host_data,
   input  wire logic [17:0] dev_data,
   input  wire logic [1:0]  dev_oe_n,
   output logic      [17:0] bus_level
);
   logic [17:0] last_reg = 18'h15555;
   // an undriven lane shows the inverse of its last level, never a held value
   always_comb begin
      bus_level = ~last_reg;
      if (host_drive) bus_level = host_data;
      if (!dev_oe_n[0]) bus_level[8:0] = dev_data[8:0];
      if (!dev_oe_n[1]) bus_level[17:9] = dev_data[17:9];
   end
   // remember the wire so that a floating bus keeps changing
   always_ff @(posedge clock) begin
      last_reg <= bus_level;
   end
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [2:0] ON = 3'h1; // {chip_sel_n, chip_sel2_n, chip_sel_high}
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic        adv, rw, ce_n, oe_in_n, mode, snooze, drv, rdy, stby;
   logic [2:0]  sel;
   logic [18:0] adr;
   logic [1:0]  bw;
   logic [17:0] wd, bus, keep;
   wire  [17:0] dout;
   wire  [1:0]  oe_n;
   logic [17:0] mdl [int];
   int          mismatches = 0;
   int          n_compared = 0;
   int          cycles = 0;
   sbsi_sram_port i_dut (
      .clock(clock), .sys_rst(sys_rst), .addr_upper(adr[18:2]), .addr_bit1(adr[1]),
      .addr_bit0(adr[0]), .advance_not_load(adv), .read_write(rw),
      .byte_wr_en_lane_a_n(bw[0]), .byte_wr_en_lane_b_n(bw[1]), .chip_sel_n(sel[2]),
      .chip_sel2_n(sel[1]), .chip_sel_high(sel[0]), .clk_en_n(ce_n), .out_en_n(oe_in_n),
      .burst_mode(mode), .snooze_request(snooze), .data_lane_a_in(bus[8:0]),
      .data_lane_a_out(dout[8:0]), .data_lane_a_oe_n(oe_n[0]), .data_lane_b_in(bus[17:9]),
      .data_lane_b_out(dout[17:9]), .data_lane_b_oe_n(oe_n[1]), .wr_buf_ready(rdy),
      .standby_active(stby)
   );
   sbsi_host_model i_host (
      .clock(clock), .host_drive(drv), .host_data(wd), .dev_data(dout), .dev_oe_n(oe_n),
      .bus_level(bus)
   );
   // free-running clock and a cycle ceiling against hangs
   initial begin
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one command cycle, plus the data phase of the command before it
   task automatic op(input logic a_l, input logic r, input logic [2:0] s, input logic [18:0] a,
                     input logic [1:0] b, input logic d, input logic [17:0] v);
      @(negedge clock);
      {adv, rw, sel, adr, bw, drv, wd} = {a_l, r, s, a, b, d, v};
   endtask
   function automatic logic [18:0] ba(input logic [18:0] a, input logic [1:0] k, input logic m);
      return {a[18:2], m ? a[1:0] ^ k : a[1:0] + k};
   endfunction
   task automatic see(input logic [18:0] a);
      chk("read data", bus, mdl[a]);
      chk("output enables", {16'h0, oe_n}, 18'h0);
   endtask
   task automatic wr1(input logic [18:0] a, input logic [1:0] b, input logic [17:0] v);
      op(1'b0, 1'b0, ON, a, b, 1'b0, 18'h0);
      op(1'b0, 1'b0, 3'h0, ~a, 2'h3, 1'b1, v);
      mdl[a] = {b[1] ? mdl[a][17:9] : v[17:9], b[0] ? mdl[a][8:0] : v[8:0]};
   endtask
   task automatic rd1(input logic [18:0] a);
      op(1'b0, 1'b1, ON, a, 2'h0, 1'b0, 18'h0);
      op(1'b0, 1'b0, 3'h0, ~a, 2'h0, 1'b0, 18'h0);
      see(a);
   endtask
   // four-word burst then a deselect; advances carry a false address and direction
   task automatic burst(input logic [18:0] a, input logic m, input logic w, input logic [17:0] v);
      mode = m;
      for (int j = 0; j < 5; j++) begin
         op(j != 0 && j != 4, (j == 0) ^ w, j == 4 ? 3'h0 : ON, j == 0 ? a : ~a, 2'h0,
            w && j != 0, v + 18'(j - 1));
         if (w && j < 4) mdl[ba(a, 2'(j), m)] = v + 18'(j);
         if (!w && j > 0) see(ba(a, 2'(j - 1), m));
      end
   endtask
   initial begin
      {adv, rw, sel, adr, bw, drv, wd} = '0;
      {ce_n, oe_in_n, snooze, mode} = 4'h1;
      repeat (8) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      chk("reset enables", {15'h0, oe_n, rdy}, 18'h7);
      chk("reset standby", {17'h0, stby}, 18'h0);
      // byte lanes, no-write and reads that carry low lane enables
      for (int i = 0; i < 4; i++) begin
         wr1(19'h00100, 2'h0, 18'h3FFFF);
         wr1(19'h00100, 2'(i), 18'h0A5A5 + 18'(i));
         rd1(19'h00100);
      end
      $display("test lanes done");
      burst(19'h12343, 1'b0, 1'b1, 18'h20010);
      burst(19'h12342, 1'b1, 1'b0, 18'h0);
      burst(19'h05601, 1'b1, 1'b1, 18'h10200);
      burst(19'h05603, 1'b0, 1'b0, 18'h0);
      $display("test bursts done");
      // three ways to deselect; pending read still finishes, then bus floats
      for (int i = 0; i < 3; i++) begin
         op(1'b0, 1'b1, ON, 19'h00100, 2'h0, 1'b0, 18'h0);
         op(1'b0, 1'b1, i == 0 ? 3'h5 : i == 1 ? 3'h3 : 3'h0, 19'h12342, 2'h0, 1'b0, 18'h0);
         see(19'h00100);
         op(1'b1, 1'b1, ON, 19'h12342, 2'h0, 1'b0, 18'h0);
         chk("floating", {16'h0, oe_n}, 18'h3);
      end
      $display("test deselect done");
      // output enable high floats the bus at once
      rd1(19'h12343);
      oe_in_n = 1'b1;
      #1 chk("oe high", {16'h0, oe_n}, 18'h3);
      oe_in_n = 1'b0;
      #1 see(19'h12343);
      // frozen edge: read data stands, the write seen meanwhile is lost
      op(1'b0, 1'b1, ON, 19'h12343, 2'h0, 1'b0, 18'h0);
      op(1'b0, 1'b0, ON, 19'h00100, 2'h0, 1'b1, 18'h11111);
      ce_n = 1'b1;
      see(19'h12343);
      op(1'b0, 1'b0, 3'h0, 19'h00100, 2'h0, 1'b1, 18'h22222);
      ce_n = 1'b0;
      see(19'h12343);
      rd1(19'h00100);
      $display("test freeze done");
      // snooze stalls the drain; a third word meets a full buffer and is dropped
      snooze = 1'b1;
      wr1(19'h05601, 2'h0, 18'h01234);
      wr1(19'h05602, 2'h0, 18'h04321);
      op(1'b0, 1'b0, 3'h0, 19'h0, 2'h3, 1'b0, 18'h0);
      chk("buffer full", {16'h0, rdy, stby}, 18'h1);
      keep = mdl[19'h05603];
      wr1(19'h05603, 2'h0, 18'h3C3C3);
      mdl[19'h05603] = keep;
      snooze = 1'b0;
      repeat (4) op(1'b0, 1'b0, 3'h0, 19'h0, 2'h3, 1'b0, 18'h0);
      chk("buffer drained", {16'h0, rdy, stby}, 18'h2);
      rd1(19'h05601);
      rd1(19'h05602);
      rd1(19'h05603);
      $display("test buffer done");
      stop_test();
   end
endmodule
`default_nettype wire
